// ---- hdl/cycle_watchdog.sv ----
`default_nettype none

// counts clocks while run is high; expired holds once the limit is reached
module cycle_watchdog
   import epp_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // control and result
   input  wire logic run,
   output logic      expired
);

   localparam logic [WDOG_W-1:0] LIMIT = WDOG_W'(WDOG_CYCLES);

   typedef struct packed {
      logic [WDOG_W-1:0] count;
   } wdog_state_t;

   wdog_state_t s;
   wdog_state_t next_s;

   // count up while a cycle runs, clear otherwise
   always_comb begin
      next_s = s;
      if (!run) begin
         next_s.count = '0;                          // see (R21)
      end else if (s.count != LIMIT) begin
         next_s.count = s.count + WDOG_W'(1);        // see (R21)
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign expired = run && (s.count == LIMIT);

endmodule

`default_nettype wire

// ---- hdl/epp_cycle_engine.sv ----
`default_nettype none

// parallel port register set with EPP 1.9 / 1.7 cycle engine
module epp_cycle_engine
   import epp_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // mode selection from configuration
   input  wire logic       eppEnable,
   input  wire logic       epp17Select,
   // host register port
   input  wire logic       portSelect,
   input  wire logic [2:0] hostAddr,
   input  wire logic       iorN,
   input  wire logic       iowN,
   input  wire logic [7:0] hostDataIn,
   output logic      [7:0] hostDataOut,
   output logic            hostDataOeN,
   output logic            iochrdyOut,
   output logic            iochrdyOeN,
   // cable data bus
   input  wire logic [7:0] cableDataIn,
   output logic      [7:0] cableDataOut,
   output logic            cableDataOeN,
   output logic            portDirectionOut,
   // cable control outputs
   output logic            xferDirectionN,
   output logic            dataCycleStrobeN,
   output logic            addrCycleStrobeN,
   output logic            initOut,
   // cable status inputs
   input  wire logic       peripheralHoldN,
   input  wire logic       errorN,
   input  wire logic       selectIn,
   input  wire logic       paperEnd,
   input  wire logic       ackN,
   // status view
   output logic            cycleTimeoutFlag
);

   typedef struct packed {
      cycle_state_t         state;
      logic                 iorPrev;
      logic                 iowPrev;
      logic [7:0]           dataReg;
      logic [CTL_WIDTH-1:0] ctl;
      logic                 timeout;
      logic                 cycAddr;
      logic                 cycWrite;
      logic                 hostRead;
      logic [7:0]           cycByte;
      logic                 rdyLow;
      logic                 hostDrive;
      logic [7:0]           readByte;
   } engine_state_t;

   engine_state_t s;
   engine_state_t next_s;

   logic [SYNC_W-1:0] syncIn;
   logic [SYNC_W-1:0] syncOut;
   logic              holdS;
   logic              iorS;
   logic              iowS;
   logic              wdogRun;
   logic              wdogExpired;
   logic              cycleOn;
   logic              strobeOn;
   logic              driveCable;
   logic              ctlStrobe;

   // true for the EPP address register and the four data windows
   function automatic logic epp_reg(input logic en, input logic [2:0] a);
      epp_reg = en && (a >= OFS_EPP_ADDR);           // see (R1)
   endfunction

   // pin inputs from outside the clock domain
   assign syncIn = {ackN, paperEnd, selectIn, errorN,
                    iowN, iorN, peripheralHoldN};

   input_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .asyncIn (syncIn),
      .syncOut (syncOut)
   );

   assign holdS = syncOut[SY_HOLD];
   assign iorS  = syncOut[SY_IOR];
   assign iowS  = syncOut[SY_IOW];

   // watchdog windows differ between the two timing modes
   always_comb begin
      case (s.state)
         ST_WAIT_LOW, ST_SETUP, ST_STROBE: wdogRun = 1'b1;  // see (R3)
         ST_E17_SETUP, ST_E17_STROBE:      wdogRun = 1'b1;  // see (R4)
         default:                          wdogRun = 1'b0;
      endcase
   end

   cycle_watchdog u_wdog (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (wdogRun),
      .expired (wdogExpired)
   );

   // register access, cycle launch and cycle sequencing
   always_comb begin
      logic iorFall;
      logic iorRise;
      logic iowFall;
      logic iowRise;
      logic hostDone;
      iorFall   = s.iorPrev && !iorS;
      iorRise   = !s.iorPrev && iorS;
      iowFall   = s.iowPrev && !iowS;
      iowRise   = !s.iowPrev && iowS;
      hostDone  = s.hostRead ? iorS : iowS;
      next_s    = s;
      next_s.iorPrev = iorS;
      next_s.iowPrev = iowS;

      // host read data latched at the start of the read
      if (iorFall && portSelect) begin
         next_s.hostDrive = 1'b1;
         case (hostAddr)
            OFS_SPP_DATA: next_s.readByte = cableDataIn;
            OFS_STATUS:   next_s.readByte = {~holdS, syncOut[SY_ACK],
                                             syncOut[SY_PE],
                                             syncOut[SY_SLCT],
                                             syncOut[SY_ERR], 2'b00,
                                             s.timeout};
            OFS_CONTROL:  next_s.readByte = {2'b00, s.ctl};
            default:      next_s.readByte = READ_ZERO;
         endcase
      end
      if (iorRise) begin
         next_s.hostDrive = 1'b0;
      end

      // plain registers latch on the trailing edge of the write
      if (iowRise && portSelect) begin
         case (hostAddr)
            OFS_SPP_DATA: next_s.dataReg = hostDataIn;
            OFS_STATUS: begin
               if (hostDataIn[STS_TIMEOUT_BIT]) begin
                  next_s.timeout = 1'b0;             // see (R20)
               end
            end
            OFS_CONTROL:  next_s.ctl = hostDataIn[CTL_WIDTH-1:0];
            default:      next_s.ctl = s.ctl;
         endcase
      end

      case (s.state)
         ST_IDLE: begin
            if ((iowFall || iorFall) && portSelect &&
                epp_reg(eppEnable, hostAddr)) begin  // see (R1)
               next_s.cycAddr  = (hostAddr == OFS_EPP_ADDR);  // see (R19)
               next_s.hostRead = !iowFall;
               // write with direction bit set becomes a cable read
               next_s.cycWrite = iowFall &&
                                 !s.ctl[CTL_DIR_BIT];  // see (R7)
               next_s.cycByte  = hostDataIn;
               if (epp17Select) begin
                  next_s.state = ST_E17_SETUP;
               end else begin
                  next_s.rdyLow = 1'b1;              // see (R8) (R14)
                  next_s.state  = ST_WAIT_LOW;
               end
            end
         end
         ST_WAIT_LOW: begin
            // cable outputs stay idle until the peripheral holds wait low
            if (!holdS) begin
               next_s.state = ST_SETUP;              // see (R9) (R10) (R15)
            end
         end
         ST_SETUP: begin
            next_s.state = ST_STROBE;                // see (R11) (R14)
         end
         ST_STROBE: begin
            if (holdS) begin
               if (!s.cycWrite) begin
                  next_s.readByte = cableDataIn;     // see (R16)
               end else begin
                  next_s.cycByte = hostDataIn;       // see (R12)
               end
               next_s.rdyLow = 1'b0;                 // see (R12) (R16)
               next_s.state  = ST_DONE;
            end
         end
         ST_DONE: begin
            if (hostDone) begin
               next_s.state = ST_IDLE;
            end
         end
         ST_E17_SETUP: begin
            next_s.rdyLow = !holdS;
            next_s.state  = ST_E17_STROBE;
         end
         ST_E17_STROBE: begin
            next_s.rdyLow = !holdS;
            if (holdS && !s.cycWrite) begin
               next_s.readByte = cableDataIn;
            end
            if (hostDone) begin
               next_s.rdyLow = 1'b0;
               next_s.state  = ST_IDLE;
            end
         end
         ST_ABORT: begin
            if (hostDone) begin
               next_s.state = ST_IDLE;
            end
         end
         default: begin
            next_s.state = ST_IDLE;
         end
      endcase

      // abort after the watchdog limit; set wins over a clear
      if (wdogExpired) begin
         next_s.rdyLow  = 1'b0;                      // see (R22)
         next_s.timeout = 1'b1;                      // see (R3) (R4)
         next_s.state   = ST_ABORT;                  // see (R22)
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s          <= '0;
         s.state    <= ST_IDLE;
         s.iorPrev  <= 1'b1;
         s.iowPrev  <= 1'b1;
         s.dataReg  <= DATA_RESET;
         s.ctl      <= CTL_RESET;
         s.timeout  <= 1'b0;                         // see (R20)
         s.readByte <= DATA_RESET;
      end else begin
         s <= next_s;
      end
   end

   // cable side view of the cycle
   always_comb begin
      case (s.state)
         ST_SETUP, ST_STROBE, ST_DONE,
         ST_E17_SETUP, ST_E17_STROBE: cycleOn = 1'b1;
         default:                     cycleOn = 1'b0;  // see (R2) (R22)
      endcase
   end

   assign strobeOn  = (s.state == ST_STROBE) || (s.state == ST_E17_STROBE);
   assign ctlStrobe = s.ctl[CTL_STROBE_BIT];

   // control strobe bit forces write direction inside a cycle
   assign driveCable = cycleOn ? (s.cycWrite || ctlStrobe)   // see (R5)
                               : !s.ctl[CTL_DIR_BIT];        // see (R2)

   // cable pins; idle values come from the data and control registers
   assign cableDataOut     = cycleOn ? s.cycByte : s.dataReg;  // see (R11)
   assign cableDataOeN     = !driveCable;            // see (R14)
   assign portDirectionOut = !driveCable;            // see (R11) (R14)
   assign xferDirectionN   = cycleOn ? !(s.cycWrite || ctlStrobe)  // see (R5)
                                     : !ctlStrobe;   // see (R2)
   assign dataCycleStrobeN = cycleOn ? !(strobeOn && !s.cycAddr)   // see (R19)
                                     : !s.ctl[CTL_LINE_FEED_OUT_BIT];
   assign addrCycleStrobeN = cycleOn ? !(strobeOn && s.cycAddr)    // see (R19)
                                     : !s.ctl[CTL_SELIN_BIT];
   assign initOut          = s.ctl[CTL_INIT_BIT];

   // host side pins; IOCHRDY is open drain, pulled low only
   assign hostDataOut      = s.readByte;
   assign hostDataOeN      = !s.hostDrive;
   assign iochrdyOut       = 1'b0;
   assign iochrdyOeN       = !s.rdyLow;              // see (R8) (R12)
   assign cycleTimeoutFlag = s.timeout;

endmodule

`default_nettype wire

// ---- hdl/input_sync.sv ----
`default_nettype none

// three-stage synchroniser; output changes once stages two and three agree
module input_sync
   import epp_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // asynchronous inputs and filtered result
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] stage3;
      logic [WIDTH-1:0] level;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // shift chain and agreement filter; stage1 feeds stage2 only
   always_comb begin
      next_s        = s;
      next_s.stage1 = asyncIn;
      next_s.stage2 = s.stage1;
      next_s.stage3 = s.stage2;
      for (int i = 0; i < WIDTH; i++) begin
         if (s.stage2[i] == s.stage3[i]) begin
            next_s.level[i] = s.stage3[i];
         end
      end
   end

   // state register; inputs idle high after reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '{default: '1};
      end else begin
         s <= next_s;
      end
   end

   assign syncOut = s.level;

endmodule

`default_nettype wire

// ---- include/epp_pkg.sv ----
// Function
// (R1) EPP data windows at 05H, 06H, 07H mirror data window 0, EPP mode only.
// (R2) Outside EPP cycles the cable bus follows control register and direction bit.
// (R3) EPP 1.9 watchdog: host strobe to wait deassertion over 10us aborts, sets flag.
// (R4) EPP 1.7 watchdog: host strobe assertion to release over 10us aborts, sets flag.
// (R5) Control strobe bit during an EPP cycle forces write direction on cable.
// (R6) Software clears the direction bit before any EPP 1.9 cycle.
// (R7) Write attempted with direction bit set runs a cable read, no error.
// (R8) EPP 1.9 write pulls IOCHRDY low until completion is decided.
// (R9) Wait already low at strobe time: write completes when wait goes high.
// (R10) Wait high at write start: hold strobes and direction until it goes low.
// (R11) Write: drive byte, clear port direction, assert write, then strobe.
// (R12) Wait deasserted on write: drop strobe, latch byte, release IOCHRDY.
// (R13) Peripheral releases wait after setup, latches byte, reasserts wait.
// (R14) Read: pull IOCHRDY low, await wait low, float bus, set direction, strobe.
// (R15) Read with wait high: hold direction and strobe until it goes low.
// (R16) Wait deasserted on read: latch cable byte, drop strobe, answer host.
// (R17) Peripheral drives data, releases wait, then floats bus, reasserts wait.
// (R18) EPP 1.7 software clears D0, D1, D3 and sets direction per transfer.
// (R19) Address register accesses use address strobe, data windows data strobe.
// (R20) Timeout flag cleared by reset or writing one; writing zero does nothing.
// (R21) Watchdog counts clocks to ten microseconds, cleared when no cycle active.
// (R22) Abort drops both strobes, releases IOCHRDY, returns cable bus to idle.
`default_nettype none

package epp_pkg;

   // register offsets from the port base
   localparam logic [2:0] OFS_SPP_DATA  = 3'h0;
   localparam logic [2:0] OFS_STATUS    = 3'h1;
   localparam logic [2:0] OFS_CONTROL   = 3'h2;
   localparam logic [2:0] OFS_EPP_ADDR  = 3'h3;
   localparam logic [2:0] OFS_EPP_DATA0 = 3'h4;
   localparam logic [2:0] OFS_EPP_DATA1 = 3'h5;
   localparam logic [2:0] OFS_EPP_DATA2 = 3'h6;
   localparam logic [2:0] OFS_EPP_DATA3 = 3'h7;

   // control register fields
   localparam int CTL_STROBE_BIT = 0;
   localparam int CTL_LINE_FEED_OUT_BIT = 1;
   localparam int CTL_INIT_BIT   = 2;
   localparam int CTL_SELIN_BIT  = 3;
   localparam int CTL_DIR_BIT    = 5;
   localparam int CTL_WIDTH      = 6;

   // status register fields
   localparam int STS_TIMEOUT_BIT = 0;

   // reset values
   localparam logic [7:0]  DATA_RESET = 8'h00;
   localparam logic [5:0]  CTL_RESET  = 6'h00;
   localparam logic [7:0]  READ_ZERO  = 8'h00;

   // synchroniser lanes
   localparam int SYNC_W      = 7;
   localparam int SY_HOLD     = 0;
   localparam int SY_IOR      = 1;
   localparam int SY_IOW      = 2;
   localparam int SY_ERR      = 3;
   localparam int SY_SLCT     = 4;
   localparam int SY_PE       = 5;
   localparam int SY_ACK      = 6;

   // watchdog timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int WDOG_TIME_NS  = 10000;
   localparam int WDOG_CYCLES   = WDOG_TIME_NS / CLK_PERIOD_NS;
   localparam int WDOG_W        = 9;

   // cycle engine states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_WAIT_LOW,
      ST_SETUP,
      ST_STROBE,
      ST_DONE,
      ST_E17_SETUP,
      ST_E17_STROBE,
      ST_ABORT
   } cycle_state_t;

endpackage

`default_nettype wire

// ---- tb/epp_engine_properties.sv ----
`default_nettype none

// protocol watcher bound onto the cycle engine ports
module epp_engine_properties
   import epp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host side
   input wire logic epp17Select,
   input wire logic iorN,
   input wire logic iowN,
   input wire logic iochrdyOeN,
   // cable side
   input wire logic cableDataOeN,
   input wire logic portDirectionOut,
   input wire logic xferDirectionN,
   input wire logic dataCycleStrobeN,
   input wire logic addrCycleStrobeN,
   input wire logic cycleTimeoutFlag
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [8:0] lowCnt;
   logic [3:0] idleCnt;
   // length of not-ready stretch and of quiet write strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lowCnt <= 9'h000;
         idleCnt <= 4'h0;
      end else begin
         lowCnt <= iochrdyOeN ? 9'h000 : lowCnt + 9'h001;
         idleCnt <= !iowN ? 4'h0 : idleCnt + {3'h0, idleCnt != 4'hF};
      end
   end
   sequence hostBusy;
      !(iowN && iorN) && !epp17Select;
   endsequence
   sequence strobeOn;
      $fell(dataCycleStrobeN) || $fell(addrCycleStrobeN);
   endsequence
   chk_strobe_exclusive: assert property (hostBusy |->
      dataCycleStrobeN || addrCycleStrobeN) else $error("both strobes");
   chk_port_direction_out_tracks: assert property (
      portDirectionOut == cableDataOeN)
      else $error("direction out differs from drive");
   // inside a cycle only: idle pins follow the control register freely
   chk_write_drives: assert property (!iochrdyOeN &&
      !(dataCycleStrobeN && addrCycleStrobeN) && !xferDirectionN
      |-> !cableDataOeN) else $error("write strobe without drive");
   chk_read_floats: assert property (!iochrdyOeN &&
      !(dataCycleStrobeN && addrCycleStrobeN) && xferDirectionN
      |-> cableDataOeN) else $error("read strobe with drive");
   chk_rdy_on_strobe: assert property (strobeOn ##0 hostBusy
      |-> !iochrdyOeN) else $error("strobe while ready");
   chk_release_ends: assert property ($rose(iochrdyOeN) &&
      !epp17Select |-> dataCycleStrobeN && addrCycleStrobeN)
      else $error("ready with strobe on");
   chk_rdy_bounded: assert property (lowCnt <= 9'h0FF)
      else $error("not ready too long");
   chk_abort_idle: assert property ($rose(cycleTimeoutFlag) |->
      ##[0:1] (iochrdyOeN && dataCycleStrobeN && addrCycleStrobeN))
      else $error("abort left cycle");
   chk_flag_sticky: assert property (cycleTimeoutFlag &&
      idleCnt >= 4'h8 |=> cycleTimeoutFlag) else $error("flag lost");
   chk_flag_cause: assert property ($rose(cycleTimeoutFlag) &&
      !epp17Select |-> $past(lowCnt) >= 9'h0F0)
      else $error("early timeout");
endmodule

`default_nettype wire

// ---- tb/epp_peer_model.sv ----
`default_nettype none

// peripheral on the cable: interlocked wait handshake
module epp_peer_model
   import epp_pkg::*;
(
   // clock
   input wire logic       clk,
   // behaviour control
   input wire logic       stall,
   input wire logic [3:0] lag,
   input wire logic [7:0] replyByte,
   // cable from device
   input wire logic       dataCycleStrobeN,
   input wire logic       addrCycleStrobeN,
   input wire logic       xferDirectionN,
   input wire logic [7:0] cableDataOut,
   // cable to device and observations
   output logic           peripheralHoldN,
   output logic [7:0]     peerByte,
   output logic [7:0]     gotByte,
   output logic           gotAddr,
   output logic           gotWrite
);
   timeunit 1ns;
   timeprecision 100ps;
   // one transfer per strobe; stall never releases wait
   initial begin
      peripheralHoldN = 1'b0;
      peerByte = 8'h00;
      gotByte = 8'h00;
      gotAddr = 1'b0;
      gotWrite = 1'b0;
      forever begin
         @(posedge clk) #2;
         if (!(dataCycleStrobeN && addrCycleStrobeN)) begin
            gotAddr = !addrCycleStrobeN;
            gotWrite = !xferDirectionN;
            repeat (lag) @(posedge clk);
            #2 peerByte = replyByte;
            @(posedge clk) #2;
            gotByte = cableDataOut;
            peripheralHoldN = !stall;
            wait (dataCycleStrobeN && addrCycleStrobeN);
            @(posedge clk) #2;
            peerByte = ~peerByte;
            peripheralHoldN = 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// ---- tb/tb_epp_cycle_engine.sv ----
`default_nettype none

module tb_epp_cycle_engine
   import epp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, sys_rst, eppEnable, epp17Select, portSelect, iorN, iowN;
   logic [2:0] hostAddr;
   logic [7:0] hostDataIn, hostDataOut, cableDataIn, cableDataOut;
   logic hostDataOeN, iochrdyOeN, cableDataOeN, xferDirectionN;
   logic dataCycleStrobeN, addrCycleStrobeN, initOut, holdN, flag;
   logic stall, gotAddr, gotWrite, rdyOut, pdirOut;
   logic [3:0] lag;
   logic [7:0] replyByte, peerByte, gotByte, q;
   int failures, checksDone, i;

   // device drives, else the peer's value (inverted when released)
   assign cableDataIn = cableDataOeN ? peerByte : cableDataOut;

   epp_cycle_engine uut (.clk(clk), .sys_rst(sys_rst),
      .eppEnable(eppEnable), .epp17Select(epp17Select),
      .portSelect(portSelect), .hostAddr(hostAddr), .iorN(iorN),
      .iowN(iowN), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
      .hostDataOeN(hostDataOeN), .iochrdyOut(rdyOut),
      .iochrdyOeN(iochrdyOeN),
      .cableDataIn(cableDataIn), .cableDataOut(cableDataOut),
      .cableDataOeN(cableDataOeN), .portDirectionOut(pdirOut),
      .xferDirectionN(xferDirectionN), .dataCycleStrobeN(dataCycleStrobeN),
      .addrCycleStrobeN(addrCycleStrobeN), .initOut(initOut),
      .peripheralHoldN(holdN), .errorN(1'b1), .selectIn(1'b1),
      .paperEnd(1'b0), .ackN(1'b1), .cycleTimeoutFlag(flag));

   epp_peer_model peer (.clk(clk), .stall(stall), .lag(lag),
      .replyByte(replyByte), .dataCycleStrobeN(dataCycleStrobeN),
      .addrCycleStrobeN(addrCycleStrobeN),
      .xferDirectionN(xferDirectionN), .cableDataOut(cableDataOut),
      .peripheralHoldN(holdN), .peerByte(peerByte), .gotByte(gotByte),
      .gotAddr(gotAddr), .gotWrite(gotWrite));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one host strobe, held until the device is ready
   task automatic hostAcc(input logic wr, input logic [2:0] a,
                          input logic [7:0] d);
      int n;
      @(posedge clk) #2;
      hostAddr = a;
      hostDataIn = d;
      iowN = !wr;
      iorN = wr;
      repeat (6) @(posedge clk);
      #2 n = 0;
      while (iochrdyOeN !== 1'b1 && n < 400) begin
         @(posedge clk) #2;
         n++;
      end
      if (n == 400) chk(8'h01, 8'h00);
      q = hostDataOut;
      chk({7'h00, hostDataOeN}, {7'h00, wr});
      iowN = 1'b1;
      iorN = 1'b1;
      repeat (8) @(posedge clk);
      #2;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("[FAIL] %0t run hung", $time);
      wrap_up();
   end

   // test sequence
   initial begin
      {sys_rst, eppEnable, portSelect, iorN, iowN} = 5'h1F;
      {epp17Select, stall, hostAddr, hostDataIn} = '0;
      lag = 4'h1;
      replyByte = 8'h00;
      failures = 0;
      checksDone = 0;
      repeat (4) @(posedge clk);
      #2 sys_rst = 1'b0;
      repeat (4) @(posedge clk);
      #2 chk({7'h00, rdyOut}, 8'h00);
      hostAcc(1'b0, OFS_CONTROL, 8'h00);
      chk(q, 8'h00);
      hostAcc(1'b1, OFS_CONTROL, 8'h04);
      for (i = 4; i < 8; i++) begin
         hostAcc(1'b1, 3'(i), 8'hA0 + 8'(i));
         chk(gotByte, 8'hA0 + 8'(i));
         chk({6'h00, gotAddr, gotWrite}, 8'h01);
         replyByte = 8'h5A ^ 8'(i);
         lag = 4'(i);
         hostAcc(1'b0, 3'(i), 8'h00);
         chk(q, 8'h5A ^ 8'(i));
         chk({6'h00, gotAddr, gotWrite}, 8'h00);
      end
      $display("done: data windows");
      hostAcc(1'b1, OFS_EPP_ADDR, 8'hC3);
      chk(gotByte, 8'hC3);
      chk({6'h00, gotAddr, gotWrite}, 8'h03);
      eppEnable = 1'b0;
      hostAcc(1'b0, OFS_EPP_DATA1, 8'h00);
      chk(q, 8'h00);
      chk({7'h00, gotAddr}, 8'h01);
      eppEnable = 1'b1;
      hostAcc(1'b1, OFS_CONTROL, 8'h24);
      hostAcc(1'b1, OFS_EPP_DATA0, 8'h99);
      chk({7'h00, gotWrite}, 8'h00);
      hostAcc(1'b1, OFS_CONTROL, 8'h05);
      hostAcc(1'b0, OFS_EPP_DATA0, 8'h00);
      chk({7'h00, gotWrite}, 8'h01);
      $display("done: direction overrides");
      hostAcc(1'b1, OFS_CONTROL, 8'h07);
      chk({2'h0, pdirOut, xferDirectionN, dataCycleStrobeN,
           addrCycleStrobeN, initOut, cableDataOeN}, 8'h06);
      hostAcc(1'b1, OFS_CONTROL, 8'h28);
      chk({2'h0, pdirOut, xferDirectionN, dataCycleStrobeN,
           addrCycleStrobeN, initOut, cableDataOeN}, 8'h39);
      hostAcc(1'b1, OFS_CONTROL, 8'h04);
      $display("done: idle follows control");
      for (i = 0; i < 2; i++) begin
         epp17Select = i[0];
         stall = 1'b1;
         hostAcc(1'b1, OFS_EPP_DATA0, 8'h11);
         stall = 1'b0;
         chk({7'h00, flag}, 8'h01);
         hostAcc(1'b0, OFS_STATUS, 8'h00);
         chk({7'h00, q[STS_TIMEOUT_BIT]}, 8'h01);
         hostAcc(1'b1, OFS_STATUS, 8'h00);
         hostAcc(1'b0, OFS_STATUS, 8'h00);
         chk({7'h00, q[STS_TIMEOUT_BIT]}, 8'h01);
         hostAcc(1'b1, OFS_STATUS, 8'h01);
         chk({7'h00, flag}, 8'h00);
         hostAcc(1'b0, OFS_STATUS, 8'h00);
         chk({7'h00, q[STS_TIMEOUT_BIT]}, 8'h00);
      end
      hostAcc(1'b1, OFS_EPP_DATA2, 8'h3C);
      chk(gotByte, 8'h3C);
      $display("done: watchdog");
      wrap_up();
   end
endmodule

bind epp_cycle_engine epp_engine_properties chk (.clk(clk),
   .sys_rst(sys_rst), .epp17Select(epp17Select), .iorN(iorN), .iowN(iowN),
   .iochrdyOeN(iochrdyOeN), .cableDataOeN(cableDataOeN),
   .portDirectionOut(portDirectionOut), .xferDirectionN(xferDirectionN),
   .dataCycleStrobeN(dataCycleStrobeN), .addrCycleStrobeN(addrCycleStrobeN),
   .cycleTimeoutFlag(cycleTimeoutFlag));

`default_nettype wire
